// File: tpe_pkg.sv
// Types shared by the tunnel encapsulator modules
package tpe_pkg;

  typedef enum logic [1:0] {
    TPE_DATA = 2'b00,
    TPE_ROW  = 2'b01,
    TPE_COL  = 2'b10
  } tpe_state_t;

  typedef enum logic [1:0] {
    TPE_S_TUN  = 2'b00,
    TPE_S_COL  = 2'b01,
    TPE_S_ROW  = 2'b10
  } tpe_stream_t;

endpackage : tpe_pkg

// File: tpe_regs.svh
// Register map, field values, reset values and fixed sizes of the tunnel encapsulator
`ifndef TPE_REGS_SVH
`define TPE_REGS_SVH

// ============================================================
// Register byte addresses
`define TPE_A_CTRL      12'h000
`define TPE_A_PAYLEN    12'h004
`define TPE_A_FECDIM    12'h008
`define TPE_A_GROUP     12'h00c
`define TPE_A_PORT      12'h010
`define TPE_A_STATUS    12'h014
`define TPE_A_MASK      12'h018
`define TPE_A_SEQ       12'h01c

// ============================================================
// Field values and reset values
`define TPE_MODE_NONE   2'h0
`define TPE_MODE_COL    2'h1
`define TPE_MODE_2D     2'h2
`define TPE_PT_DATA     7'h51
`define TPE_PT_LINK     7'h52
`define TPE_PT_STUDIO   7'h61
`define TPE_MC_PREFIX   8'hef
`define TPE_RST_LENM1   6'h3f
`define TPE_RST_DIMM1   4'hf
`define TPE_RST_GROUP   24'h000001
`define TPE_RST_PORT    16'h1388
`define TPE_RST_SEQ     16'h0000
`define TPE_PORT_STEP   16'h0002

// ============================================================
// Fixed sizes: stores for payloads of up to 64 bytes and arrays of up to 16 x 16 = 256 packets
`define TPE_NSRC        2
`define TPE_NOUT        3
`define TPE_COL_DEPTH   1024
`define TPE_ROW_DEPTH   64
`define TPE_NEV         3

`endif

// File: tpe_seq_gen.sv
// Per-output-stream 16-bit sequence counters
`timescale 1ns/1ps
`include "tpe_regs.svh"
module tpe_seq_gen (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [2:0]  inc,
  output logic      [47:0] seq
);
  genvar k;
  generate
    for (k = 0; k < `TPE_NOUT; k++) begin : g_seq
      logic [15:0] seq_ff;
      // Natural 16-bit wrap gives modulo 65536
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) seq_ff <= `TPE_RST_SEQ;
        else if (ce && inc[k]) seq_ff <= seq_ff + 16'h0001;
      end
      assign seq[k*16 +: 16] = seq_ff;
    end
  endgenerate
endmodule : tpe_seq_gen

// File: tpe_sink_model.sv
// Far-end sink model: checks framing, addressing, sequence and xor parity of the stream
`timescale 1ns/1ps
module tpe_sink_model #(
  parameter logic [15:0] BASE_PORT = 16'h1388
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 tx_valid,
  input  wire logic [7:0]           tx_data,
  input  wire logic                 tx_first,
  input  wire logic                 tx_last,
  input  wire tpe_pkg::tpe_stream_t tx_stream,
  input  wire logic [31:0]          tx_ip,
  input  wire logic [15:0]          tx_port,
  input  wire logic [15:0]          tx_seq,
  input  wire logic                 tx_marker,
  input  wire logic [15:0]          tx_offset,
  input  wire logic [5:0]           lenm1,
  input  wire logic [3:0]           lm1,
  output int                        errs,
  output int                        tun_pkts,
  output int                        par_pkts
);
  import tpe_pkg::*;
  logic [7:0]  colx [16][64];
  logic [7:0]  rowx [64];
  logic [15:0] last_seq [3];
  bit          seen [3];
  bit          st_seen;
  int          st_idx;
  int          idx;
  int          pk;
  int          colk;
  int          s;
  // ============================================================
  // Byte walk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      errs = 0;
      tun_pkts = 0;
      par_pkts = 0;
      pk = 0;
      colk = 0;
      idx = 0;
      st_seen = 1'b0;
      st_idx = 0;
      seen = '{default: 0};
      foreach (colx[i, j]) colx[i][j] = 8'h00;
      foreach (rowx[j]) rowx[j] = 8'h00;
    end else if (tx_valid) begin
      s = int'(tx_stream);
      if (tx_first) begin
        idx = 0;
        st_seen = 1'b0;
      end
      if (tx_ip[31:24] !== 8'hef || tx_port !== BASE_PORT + 16'(2 * s)) errs++;
      if (tx_first && seen[s] && tx_seq !== last_seq[s] + 16'h0001) errs++;
      // Inner packets are four bytes, so a start carries a count ending in 00
      if (tx_stream == TPE_S_TUN && tx_data[1:0] == 2'b00 && !st_seen) begin
        st_seen = 1'b1;
        st_idx = idx;
      end
      if (tx_first) begin
        seen[s] = 1'b1;
        last_seq[s] = tx_seq;
      end
      // Longer payloads than the array are not checked byte by byte
      if (idx < 64) begin
        case (tx_stream)
          TPE_S_TUN: begin
            colx[pk % (int'(lm1) + 1)][idx] ^= tx_data;
            rowx[idx] ^= tx_data;
          end
          TPE_S_ROW: begin
            if (rowx[idx] !== tx_data) errs++;
            rowx[idx] = 8'h00;
          end
          default: begin
            if (colx[colk][idx] !== tx_data) errs++;
            colx[colk][idx] = 8'h00;
          end
        endcase
      end
      if (tx_last) begin
        if (idx != int'(lenm1)) errs++;
        if (tx_marker !== st_seen) errs++;
        if (tx_offset !== (st_seen ? 16'(st_idx) : 16'h0000)) errs++;
        if (tx_stream == TPE_S_TUN) begin
          tun_pkts++;
          pk++;
        end else begin
          par_pkts++;
        end
        if (tx_stream == TPE_S_COL) colk++;
        if (colk > int'(lm1)) begin
          colk = 0;
          pk = 0;
        end
      end
      idx++;
    end
  end
endmodule : tpe_sink_model

// File: tpe_top.sv
// Tunnel encapsulator with column/row xor correction and APB registers
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "tpe_regs.svh"
module tpe_top (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic [1:0]        in_valid,
  input  wire logic [15:0]       in_data,
  input  wire logic [1:0]        in_last,
  output logic      [1:0]        in_ready,
  output logic                   tx_valid,
  output logic      [7:0]        tx_data,
  output logic                   tx_first,
  output logic                   tx_last,
  output tpe_pkg::tpe_stream_t   tx_stream,
  output logic      [31:0]       tx_ip,
  output logic      [15:0]       tx_port,
  output logic      [6:0]        tx_pt,
  output logic      [15:0]       tx_seq,
  output logic                   tx_marker,
  output logic      [15:0]       tx_offset
);
  import tpe_pkg::*;

  // ============================================================
  // Configuration and status
  logic        pready_ff, pslverr_ff, irq_ff, en_ff, mat_pend_ff;
  logic [31:0] prdata_ff;
  logic [1:0]  mode_ff, ptsel_ff;
  logic [5:0]  lenm1_ff;
  logic [3:0]  colsm1_ff, rowsm1_ff;
  logic [23:0] group_ff;
  logic [15:0] port_ff;
  logic [2:0]  status_ff, mask_ff, nxt_status;
  logic [2:0]  ev;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [47:0] seq_all;
  logic [6:0]  pt_code;

  wire apb_done = psel & penable & pready_ff;
  wire apb_wr   = apb_done & pwrite;
  wire apb_rd   = apb_done & ~pwrite;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `TPE_A_CTRL:   rd_val = {27'h0, ptsel_ff, mode_ff, en_ff};
      `TPE_A_PAYLEN: rd_val = {26'h0, lenm1_ff};
      `TPE_A_FECDIM: rd_val = {24'h0, rowsm1_ff, colsm1_ff};
      `TPE_A_GROUP:  rd_val = {`TPE_MC_PREFIX, group_ff};
      `TPE_A_PORT:   rd_val = {16'h0, port_ff};
      `TPE_A_STATUS: rd_val = {29'h0, status_ff};
      `TPE_A_MASK:   rd_val = {29'h0, mask_ff};
      `TPE_A_SEQ:    rd_val = {16'h0, seq_all[15:0]};
      default:       rd_hit = 1'b0;
    endcase
  end

  // One wait state: answer on the second access-phase edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff  <= psel & penable & ~pready_ff;
      prdata_ff  <= (psel & penable & ~pready_ff & ~pwrite) ? rd_val : 32'h0000_0000;
      pslverr_ff <= psel & penable & ~pready_ff & ~rd_hit;
    end
  end

  // Settings should only change while disabled; mid-block changes corrupt parity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff     <= 1'b0;
      mode_ff   <= `TPE_MODE_2D;
      ptsel_ff  <= 2'h0;
      lenm1_ff  <= `TPE_RST_LENM1;
      colsm1_ff <= `TPE_RST_DIMM1;
      rowsm1_ff <= `TPE_RST_DIMM1;
      group_ff  <= `TPE_RST_GROUP;
      port_ff   <= `TPE_RST_PORT;
      mask_ff   <= 3'h0;
    end else if (ce && apb_wr) begin
      unique case (paddr)
        `TPE_A_CTRL: begin
          en_ff    <= pwdata[0];
          mode_ff  <= pwdata[2:1];
          ptsel_ff <= pwdata[4:3];
        end
        `TPE_A_PAYLEN: lenm1_ff <= pwdata[5:0];
        `TPE_A_FECDIM: begin
          colsm1_ff <= pwdata[3:0];
          rowsm1_ff <= pwdata[7:4];
        end
        `TPE_A_GROUP:  group_ff <= pwdata[23:0];
        `TPE_A_PORT:   port_ff  <= pwdata[15:0];
        `TPE_A_MASK:   mask_ff  <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read clears status; a same-cycle event still sets its bit
  assign nxt_status = (status_ff & ~{3{apb_rd && paddr == `TPE_A_STATUS}}) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= 3'h0;
      irq_ff    <= 1'b0;
    end else if (ce) begin
      status_ff <= nxt_status;
      irq_ff    <= |(nxt_status & mask_ff);
    end
  end

  // Unused select code falls back to data-source tunneling
  always_comb begin
    unique case (ptsel_ff)
      2'h1:    pt_code = `TPE_PT_LINK;
      2'h2:    pt_code = `TPE_PT_STUDIO;
      default: pt_code = `TPE_PT_DATA;
    endcase
  end

  // ============================================================
  // Packing and parity sequencing
  tpe_state_t  state_ff, nxt_state;
  logic [5:0]  idx_ff;
  logic [3:0]  col_ff, row_ff, fc_ff;
  logic        src_ff, nxt_src, in_pkt_ff, nxt_in_pkt, mark_ff;
  logic [15:0] offs_ff;
  logic [1:0]  in_ready_ff;
  logic [7:0]  col_rd, row_rd, byte_val;

  wire take      = state_ff == TPE_DATA && (|(in_valid & in_ready_ff));
  wire emit_fec  = state_ff != TPE_DATA;
  wire byte_go   = take | emit_fec;
  wire last_byte = byte_go && idx_ff == lenm1_ff;
  wire start_now = take & ~in_pkt_ff;
  wire row_end   = col_ff == colsm1_ff;
  wire mat_end   = row_end && row_ff == rowsm1_ff;
  wire col_on    = mode_ff == `TPE_MODE_COL || mode_ff == `TPE_MODE_2D;
  wire row_on    = mode_ff == `TPE_MODE_2D;
  wire [7:0] in_byte = in_data[{src_ff, 3'h0} +: 8];

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      TPE_DATA: if (take && last_byte) begin
        if (row_on && row_end) nxt_state = TPE_ROW;
        else if (col_on && mat_end) nxt_state = TPE_COL;
      end
      TPE_ROW:  if (last_byte) nxt_state = mat_pend_ff ? TPE_COL : TPE_DATA;
      TPE_COL:  if (last_byte && fc_ff == colsm1_ff) nxt_state = TPE_DATA;
      default:  nxt_state = TPE_DATA;
    endcase
  end

  // Sources switch only between inner packets, alternating when both wait
  assign nxt_in_pkt = take ? ~in_last[src_ff] : in_pkt_ff;
  assign nxt_src    = (nxt_in_pkt || !in_valid[~src_ff]) ? src_ff : ~src_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= TPE_DATA;
      src_ff      <= 1'b0;
      in_pkt_ff   <= 1'b0;
      in_ready_ff <= 2'h0;
    end else if (ce) begin
      state_ff    <= nxt_state;
      src_ff      <= nxt_src;
      in_pkt_ff   <= nxt_in_pkt;
      in_ready_ff <= (en_ff && nxt_state == TPE_DATA) ? (nxt_src ? 2'h2 : 2'h1) : 2'h0;
    end
  end

  // Byte index in payload and position in the packet array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_ff      <= 6'h00;
      col_ff      <= 4'h0;
      row_ff      <= 4'h0;
      fc_ff       <= 4'h0;
      mat_pend_ff <= 1'b0;
    end else if (ce && byte_go) begin
      idx_ff <= last_byte ? 6'h00 : idx_ff + 6'h01;
      if (take && last_byte) begin
        col_ff      <= row_end ? 4'h0 : col_ff + 4'h1;
        row_ff      <= mat_end ? 4'h0 : (row_end ? row_ff + 4'h1 : row_ff);
        mat_pend_ff <= col_on && mat_end;
      end
      if (state_ff == TPE_COL && last_byte) begin
        fc_ff       <= (fc_ff == colsm1_ff) ? 4'h0 : fc_ff + 4'h1;
        mat_pend_ff <= fc_ff != colsm1_ff;
      end
    end
  end

  // First inner-packet start in a payload is recorded once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mark_ff <= 1'b0;
      offs_ff <= 16'h0000;
    end else if (ce && take) begin
      if (last_byte) begin
        mark_ff <= 1'b0;
        offs_ff <= 16'h0000;
      end else if (start_now && !mark_ff) begin
        mark_ff <= 1'b1;
        offs_ff <= {10'h000, idx_ff};
      end
    end
  end

  tpe_xor_acc #(.DEPTH(`TPE_COL_DEPTH), .AW(10)) u_col_acc (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .acc_en   (take && col_on),
    .acc_addr ({col_ff, idx_ff}),
    .acc_data (in_byte),
    .rd_clr   (state_ff == TPE_COL),
    .rd_addr  ({fc_ff, idx_ff}),
    .rd_data  (col_rd)
  );

  tpe_xor_acc #(.DEPTH(`TPE_ROW_DEPTH), .AW(6)) u_row_acc (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .acc_en   (take && row_on),
    .acc_addr (idx_ff),
    .acc_data (in_byte),
    .rd_clr   (state_ff == TPE_ROW),
    .rd_addr  (idx_ff),
    .rd_data  (row_rd)
  );

  tpe_seq_gen u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .inc     ({last_byte && state_ff == TPE_ROW,
               last_byte && state_ff == TPE_COL,
               last_byte && state_ff == TPE_DATA}),
    .seq     (seq_all)
  );

  // ============================================================
  // Output byte stream with header sideband
  tpe_stream_t out_sid;
  logic        tx_valid_ff, tx_first_ff, tx_last_ff, tx_marker_ff;
  logic [7:0]  tx_data_ff;
  tpe_stream_t tx_stream_ff;
  logic [31:0] tx_ip_ff;
  logic [15:0] tx_port_ff, tx_seq_ff, tx_offset_ff;
  logic [6:0]  tx_pt_ff;

  always_comb begin
    unique case (state_ff)
      TPE_ROW: begin out_sid = TPE_S_ROW; byte_val = row_rd; end
      TPE_COL: begin out_sid = TPE_S_COL; byte_val = col_rd; end
      default: begin out_sid = TPE_S_TUN; byte_val = in_byte; end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_ff  <= 1'b0;
      tx_data_ff   <= 8'h00;
      tx_first_ff  <= 1'b0;
      tx_last_ff   <= 1'b0;
      tx_stream_ff <= TPE_S_TUN;
      tx_ip_ff     <= 32'h0000_0000;
      tx_port_ff   <= 16'h0000;
      tx_pt_ff     <= 7'h00;
      tx_seq_ff    <= 16'h0000;
      tx_marker_ff <= 1'b0;
      tx_offset_ff <= 16'h0000;
    end else if (ce) begin
      tx_valid_ff <= byte_go;
      tx_first_ff <= byte_go && idx_ff == 6'h00;
      tx_last_ff  <= last_byte;
      if (byte_go) begin
        tx_data_ff   <= byte_val;
        tx_stream_ff <= out_sid;
        tx_ip_ff     <= {`TPE_MC_PREFIX, group_ff};
        tx_port_ff   <= port_ff + (out_sid == TPE_S_ROW ? `TPE_PORT_STEP << 1 :
                        (out_sid == TPE_S_COL ? `TPE_PORT_STEP : 16'h0000));
        tx_pt_ff     <= pt_code;
        tx_seq_ff    <= seq_all[{out_sid, 4'h0} +: 16];
        tx_marker_ff <= take && last_byte && (mark_ff || start_now);
        tx_offset_ff <= (take && last_byte) ?
                        (mark_ff ? offs_ff : (start_now ? {10'h000, idx_ff} : 16'h0000)) : 16'h0000;
      end
    end
  end

  assign ev = {state_ff == TPE_COL && last_byte && fc_ff == colsm1_ff,
               emit_fec && last_byte,
               take && last_byte};

  assign pready    = pready_ff;
  assign prdata    = prdata_ff;
  assign pslverr   = pslverr_ff;
  assign irq       = irq_ff;
  assign in_ready  = in_ready_ff;
  assign tx_valid  = tx_valid_ff;
  assign tx_data   = tx_data_ff;
  assign tx_first  = tx_first_ff;
  assign tx_last   = tx_last_ff;
  assign tx_stream = tx_stream_ff;
  assign tx_ip     = tx_ip_ff;
  assign tx_port   = tx_port_ff;
  assign tx_pt     = tx_pt_ff;
  assign tx_seq    = tx_seq_ff;
  assign tx_marker = tx_marker_ff;
  assign tx_offset = tx_offset_ff;

  // ============================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  seq_step_a: assert property (ce && last_byte && state_ff == TPE_DATA |=>
    seq_all[15:0] == $past(seq_all[15:0]) + 16'h0001) else $error("tunnel sequence did not step");
  fixed_size_a: assert property (ce && byte_go && idx_ff == lenm1_ff |=>
    tx_valid_ff && tx_last_ff) else $error("payload did not end at set size");
  group_range_a: assert property (tx_valid_ff |-> tx_ip_ff[31:24] == `TPE_MC_PREFIX)
    else $error("group address outside local scope");
  port_map_a: assert property (tx_valid_ff && tx_stream_ff == TPE_S_ROW |->
    tx_port_ff == port_ff + 16'h0004) else $error("row parity on wrong port");
  pt_code_a: assert property (tx_valid_ff |-> tx_pt_ff inside {`TPE_PT_DATA, `TPE_PT_LINK, `TPE_PT_STUDIO})
    else $error("bad payload type");
  marker_offs_a: assert property (tx_marker_ff |-> tx_last_ff && tx_stream_ff == TPE_S_TUN &&
    tx_offset_ff <= {10'h000, lenm1_ff}) else $error("marker or offset malformed");
  row_parity_a: assert property (ce && take && last_byte && row_on && row_end |=> state_ff == TPE_ROW)
    else $error("row parity not started");
  col_parity_a: assert property (ce && state_ff == TPE_ROW && last_byte && mat_pend_ff |=>
    state_ff == TPE_COL) else $error("column parity not started");
  input_hold_a: assert property (state_ff != TPE_DATA |-> in_ready_ff == 2'h0)
    else $error("input taken during parity output");

endmodule : tpe_top

// File: tpe_top_tb_top.sv
// Self-checking testbench of the tunnel encapsulator
`timescale 1ns/1ps
`include "tpe_regs.svh"
`define CHK(g, e, m) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t %s: got %h exp %h", $time, m, g, e); \
    end \
  end
module tpe_top_tb_top;
  import tpe_pkg::*;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, tx_ip;
  logic [1:0]           in_valid, in_last, in_ready;
  logic [15:0]          in_data, tx_port, tx_seq, tx_offset;
  logic                 tx_valid, tx_first, tx_last, tx_marker, src_on;
  logic [7:0]           tx_data;
  tpe_stream_t          tx_stream;
  logic [6:0]           tx_pt;
  logic [7:0]           cnt [2];
  logic [5:0]           lenm1;
  logic [3:0]           lm1;
  int                   errs, tun_pkts, par_pkts, error_cnt, check_count, cyc, n;
  logic [11:0]          ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c};
  logic [31:0]          rv [8] = '{32'h4, 32'h3f, 32'hff, 32'hef000001, 32'h1388, 32'h0, 32'h0, 32'h0};
  logic [6:0]           pt_exp [4] = '{7'd81, 7'd82, 7'd97, 7'd81};

  tpe_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last), .tx_stream(tx_stream), .tx_ip(tx_ip),
    .tx_port(tx_port), .tx_pt(tx_pt), .tx_seq(tx_seq), .tx_marker(tx_marker), .tx_offset(tx_offset));
  tpe_sink_model sink (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_first(tx_first), .tx_last(tx_last), .tx_stream(tx_stream), .tx_ip(tx_ip), .tx_port(tx_port),
    .tx_seq(tx_seq), .tx_marker(tx_marker), .tx_offset(tx_offset), .lenm1(lenm1), .lm1(lm1), .errs(errs),
    .tun_pkts(tun_pkts), .par_pkts(par_pkts));

  // ============================================================
  // Sources: 4-byte inner packets, distinct data per source
  assign in_valid = {src_on, src_on};
  assign in_data  = {cnt[1] | 8'h80, cnt[0]};
  assign in_last  = {cnt[1][1:0] == 2'h3, cnt[0][1:0] == 2'h3};
  always @(posedge pclk) begin
    for (int k = 0; k < 2; k++) if (in_valid[k] && in_ready[k]) cnt[k] <= cnt[k] + 8'h01;
  end
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  // ============================================================
  // Bus and helper tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, exp, "read data");
    `CHK(e, exp_err, "slave error");
  endtask : rchk
  task automatic do_reset();
    src_on <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cnt <= '{8'h00, 8'h00};
    lenm1 <= 6'h07;
    lm1 <= 4'h1;
    @(posedge pclk);
  endtask : do_reset
  task automatic end_test(input string name);
    @(posedge pclk);
    src_on <= 1'b0;
    @(negedge pclk);
    `CHK(errs, 0, "sink model");
    $display("test %s done", name);
    @(posedge pclk);
  endtask : end_test

  // ============================================================
  // Scenarios
  task automatic t_regs();
    for (int i = 0; i < 8; i++) rchk(ra[i], rv[i], 1'b0);
    rchk(12'h020, 32'h0, 1'b1);
    wr(`TPE_A_GROUP, 32'h00abcdef);
    rchk(`TPE_A_GROUP, 32'hefabcdef, 1'b0);
    wr(`TPE_A_SEQ, 32'h55);
    rchk(`TPE_A_SEQ, 32'h0, 1'b0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_fec(input logic [1:0] mode, input int exp_par, input string name);
    do_reset();
    // Six-byte payloads put inner packet starts at varying offsets
    wr(`TPE_A_PAYLEN, 32'h5);
    wr(`TPE_A_FECDIM, 32'h11);
    wr(`TPE_A_CTRL, {29'h0, mode, 1'b1});
    lenm1 <= 6'h05;
    src_on <= 1'b1;
    for (n = 0; n < 5000 && par_pkts < exp_par; n++) @(negedge pclk);
    `CHK(par_pkts, exp_par, "parity packets");
    `CHK(tun_pkts, 4, "tunnel packets per block");
    end_test(name);
  endtask : t_fec
  task automatic t_irq();
    logic [31:0] r;
    logic        e;
    do_reset();
    wr(`TPE_A_PAYLEN, 32'h7);
    wr(`TPE_A_CTRL, 32'h1);
    src_on <= 1'b1;
    for (n = 0; n < 2000 && tun_pkts < 1; n++) @(negedge pclk);
    `CHK(irq, 1'b0, "masked irq");
    wr(`TPE_A_MASK, 32'h1);
    src_on <= 1'b0;
    wr(`TPE_A_CTRL, 32'h0);
    @(negedge pclk);
    `CHK(irq, 1'b1, "unmasked irq");
    apb(1'b0, `TPE_A_STATUS, 32'h0, r, e);
    `CHK(r[0], 1'b1, "status sent bit");
    repeat (2) @(negedge pclk);
    `CHK(irq, 1'b0, "irq after clear");
    `CHK(in_ready, 2'h0, "ready while disabled");
    end_test("irq");
  endtask : t_irq
  task automatic t_pt();
    for (int sel = 0; sel < 4; sel++) begin
      do_reset();
      wr(`TPE_A_PAYLEN, 32'h7);
      wr(`TPE_A_CTRL, 32'(sel << 3) | 32'h1);
      src_on <= 1'b1;
      for (n = 0; n < 2000 && tx_first !== 1'b1; n++) @(negedge pclk);
      `CHK(tx_pt, pt_exp[sel], "payload type");
      end_test("payload type");
    end
  endtask : t_pt

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  initial begin
    {presetn, psel, penable, pwrite, src_on} = 5'h0;
    {paddr, pwdata, lenm1, lm1} = '0;
    cnt = '{8'h00, 8'h00};
    {error_cnt, check_count, cyc} = '0;
    do_reset();
    t_regs();
    t_fec(2'h2, 4, "two dim");
    t_fec(2'h1, 2, "column");
    t_irq();
    t_pt();
    conclude();
  end
endmodule : tpe_top_tb_top

// File: tpe_xor_acc.sv
// Flip-flop parity store: xor-accumulate one byte, read-and-clear another
`timescale 1ns/1ps
`include "tpe_regs.svh"
module tpe_xor_acc #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          acc_en,
  input  wire logic [AW-1:0] acc_addr,
  input  wire logic [7:0]    acc_data,
  input  wire logic          rd_clr,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem_ff [DEPTH];

  assign rd_data = mem_ff[rd_addr];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      // Clearing on read leaves the entry ready for the next block
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mem_ff[i] <= 8'h00;
        else if (ce && rd_clr && rd_addr == AW'(i)) mem_ff[i] <= 8'h00;
        else if (ce && acc_en && acc_addr == AW'(i)) mem_ff[i] <= mem_ff[i] ^ acc_data;
      end
    end
  endgenerate
endmodule : tpe_xor_acc
